// *** verilog/prw_pkg.sv ***
package prw_pkg;
   // Lock bit position inside the system configuration register
   localparam int PRW_LOCK_BIT = 13;
   // One-way bit position inside device configuration word three
   localparam int PRW_ONE_WAY_BIT = 29;
   localparam int PRW_SEL_W = 4;
   localparam int PRW_NUM_OUT = 8;
   localparam int PRW_NUM_IN = 8;
   localparam int PRW_IDX_W = 4;
   localparam logic [PRW_SEL_W-1:0] PRW_SEL_RST = 4'h0;
   localparam logic [31:0] PRW_KEY1 = 32'hAA99_6655;
   localparam logic [31:0] PRW_KEY2 = 32'h5566_99AA;
   // Cycles the unlock window stays open after the second key
   localparam int PRW_UNLOCK_WIN = 16;
   localparam logic [4:0] PRW_WIN_LOAD = 5'h10;

   typedef enum logic [2:0] {
      PRW_IDLE = 3'h1,
      PRW_KEY1_OK = 3'h2,
      PRW_OPEN = 3'h4
   } prw_state_t;

   typedef struct packed {
      logic we;
      logic is_out;
      logic [PRW_IDX_W-1:0] idx;
      logic [PRW_SEL_W-1:0] sel;
   } prw_map_wr_t;

   typedef struct packed {
      logic we;
      logic val;
   } prw_lock_wr_t;
endpackage : prw_pkg

// *** verilog/prw_sel_mem.sv ***
module prw_sel_mem
   import prw_pkg::*;
#(
   parameter int DEPTH = 8
) (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic we_i,
   input wire logic [PRW_IDX_W-1:0] waddr_i,
   input wire logic [PRW_SEL_W-1:0] wdata_i,
   output logic [DEPTH*PRW_SEL_W-1:0] rdata_o
);
   logic [DEPTH*PRW_SEL_W-1:0] mem_r;
   logic [DEPTH*PRW_SEL_W-1:0] mem_nxt;

   always_comb begin
      mem_nxt = mem_r;
      if (we_i && (32'(waddr_i) < DEPTH)) begin
         mem_nxt[waddr_i*PRW_SEL_W +: PRW_SEL_W] = wdata_i;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         mem_r <= {DEPTH{PRW_SEL_RST}};
      end else begin
         mem_r <= mem_nxt;
      end
   end

   assign rdata_o = mem_r;
endmodule : prw_sel_mem

// *** verilog/prw_remap_lock.sv ***
// Notes on behaviour
// - Mapping writes are dropped silently while the lock is set.
// - Lock sits at bit 13 of system configuration; one blocks, zero permits.
// - With one-way bit 29 set, lock cannot be cleared once set.
// - One-way and locked: unlock sequence ignored, mapping stays unwritable.
// - One-way lock clears only through device reset.
// - Unprogrammed configuration reads one-way as set.
// - Output selections reset to zero, the null output.
// - Each selection field is four bits wide.
module prw_remap_lock
   import prw_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic [31:0] dev_cfg3_i,
   input wire logic cfg_programmed_i,
   input wire logic key_we_i,
   input wire logic [31:0] key_data_i,
   input wire prw_lock_wr_t lock_wr_i,
   input wire prw_map_wr_t map_wr_i,
   output logic remap_write_lock_o,
   output logic [31:0] sys_cfg_o,
   output logic unlocked_o,
   output logic one_way_o,
   output logic [PRW_NUM_OUT*PRW_SEL_W-1:0] out_sel_o,
   output logic [PRW_NUM_IN*PRW_SEL_W-1:0] in_sel_o
);
   prw_state_t st_r;
   prw_state_t st_nxt;
   logic [4:0] win_r;
   logic [4:0] win_nxt;
   logic lock_r;
   logic lock_nxt;
   logic ow_r;
   logic ow_nxt;
   logic cap_r;
   logic cap_nxt;
   logic map_ok;
   logic out_we;
   logic in_we;
   logic [31:0] sys_cfg_nxt;
   logic unlocked_nxt;

   // Key compare shared by both halves of the sequence
   function automatic logic key_hit(input logic we, input logic [31:0] data,
      input logic [31:0] key);
      return we && (data == key);
   endfunction : key_hit

   // One-way setting is captured once after reset release, not under reset
   always_comb begin
      cap_nxt = 1'b1;
      ow_nxt = ow_r;
      if (!cap_r) begin
         ow_nxt = cfg_programmed_i ? dev_cfg3_i[PRW_ONE_WAY_BIT] : 1'b1;
      end
   end

   // Reset leaves one-way set, so the strict default holds until capture
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         ow_r <= 1'b1;
         cap_r <= 1'b0;
      end else begin
         ow_r <= ow_nxt;
         cap_r <= cap_nxt;
      end
   end

   // Unlock sequence; blocked entirely under one-way lock
   always_comb begin
      st_nxt = st_r;
      win_nxt = win_r;
      unique case (st_r)
         PRW_IDLE: begin
            if (key_hit(key_we_i, key_data_i, PRW_KEY1) && !(ow_r && lock_r)) begin
               st_nxt = PRW_KEY1_OK;
            end
         end
         PRW_KEY1_OK: begin
            if (key_hit(key_we_i, key_data_i, PRW_KEY2)) begin
               st_nxt = PRW_OPEN;
               win_nxt = PRW_WIN_LOAD;
            end else if (key_we_i) begin
               st_nxt = PRW_IDLE;
            end
         end
         PRW_OPEN: begin
            win_nxt = win_r - 5'h01;
            if (win_r == 5'h01 || lock_wr_i.we) begin
               st_nxt = PRW_IDLE;
            end
         end
         default: begin
            st_nxt = PRW_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         st_r <= PRW_IDLE;
         win_r <= 5'h00;
      end else begin
         st_r <= st_nxt;
         win_r <= win_nxt;
      end
   end

   always_comb begin
      lock_nxt = lock_r;
      if (lock_wr_i.we && st_r == PRW_OPEN) begin
         if (lock_wr_i.val || !ow_r) begin
            lock_nxt = lock_wr_i.val;
         end
      end
   end

   assign map_ok = map_wr_i.we && !lock_r;
   assign out_we = map_ok && map_wr_i.is_out;
   assign in_we = map_ok && !map_wr_i.is_out;

   // Device reset is the only path that clears a one-way lock
   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         lock_r <= 1'b0;
      end else begin
         lock_r <= lock_nxt;
      end
   end

   // Outputs copy the next state, so they track it with no extra cycle of lag
   always_comb begin
      sys_cfg_nxt = 32'(lock_nxt) << PRW_LOCK_BIT;
      unlocked_nxt = (st_nxt == PRW_OPEN);
   end

   always_ff @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         remap_write_lock_o <= 1'b0;
         sys_cfg_o <= 32'h0000_0000;
         unlocked_o <= 1'b0;
         one_way_o <= 1'b1;
      end else begin
         remap_write_lock_o <= lock_nxt;
         sys_cfg_o <= sys_cfg_nxt;
         unlocked_o <= unlocked_nxt;
         one_way_o <= ow_nxt;
      end
   end

   // Selection fields held in registered memories; four bits each
   prw_sel_mem #(.DEPTH(PRW_NUM_OUT)) u_out_sel (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .we_i(out_we),
      .waddr_i(map_wr_i.idx),
      .wdata_i(map_wr_i.sel),
      .rdata_o(out_sel_o)
   );

   prw_sel_mem #(.DEPTH(PRW_NUM_IN)) u_in_sel (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .we_i(in_we),
      .waddr_i(map_wr_i.idx),
      .wdata_i(map_wr_i.sel),
      .rdata_o(in_sel_o)
   );

   property p_drop;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
         (lock_r && map_wr_i.we) |=> $stable(out_sel_o) && $stable(in_sel_o);
   endproperty
   map_write_drop_a: assert property (p_drop) else $error("mapping changed while locked");

   lock_bit_pos_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      sys_cfg_o[PRW_LOCK_BIT] == remap_write_lock_o)
      else $error("lock bit position wrong");

   one_way_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (ow_r && lock_r && cap_r) |=> lock_r)
      else $error("one-way lock cleared");

   one_way_seq_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (ow_r && lock_r && st_r == PRW_IDLE) |=> st_r == PRW_IDLE)
      else $error("unlock accepted under one-way lock");

   no_key_lock_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (st_r != PRW_OPEN) |=> $stable(lock_r))
      else $error("lock changed without unlock");

   reset_sel_a: assert property (@(posedge ref_clk_i)
      !rst_n_i |=> out_sel_o == '0)
      else $error("output selection not null after reset");

   default_ow_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (!cap_r && !cfg_programmed_i) |=> ow_r)
      else $error("unprogrammed one-way not set");

   open_win_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (st_r == PRW_KEY1_OK && key_we_i && key_data_i == PRW_KEY2) |=>
         st_r == PRW_OPEN ##[1:16] st_r == PRW_IDLE)
      else $error("unlock window length wrong");

   cov_unlock_c: cover property (@(posedge ref_clk_i) st_r == PRW_OPEN);
   cov_lock_c: cover property (@(posedge ref_clk_i) $rose(lock_r));
   cov_drop_c: cover property (@(posedge ref_clk_i) lock_r && map_wr_i.we);

   lock_reset_a: assert property (@(posedge ref_clk_i)
      !rst_n_i |=> !lock_r && !remap_write_lock_o)
      else $error("lock not cleared by reset");

   win_close_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (st_r == PRW_OPEN && win_r == 5'h01) |=> st_r == PRW_IDLE && !unlocked_o)
      else $error("unlock window overran");

   map_write_land_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (out_we && map_wr_i.idx < 4'h8) |=>
         out_sel_o[$past(map_wr_i.idx)*PRW_SEL_W +: PRW_SEL_W] == $past(map_wr_i.sel))
      else $error("output selection write lost");

   cov_timeout_c: cover property (@(posedge ref_clk_i) st_r == PRW_OPEN && win_r == 5'h01);
   cov_refuse_c: cover property (@(posedge ref_clk_i) ow_r && lock_r && key_we_i);
endmodule : prw_remap_lock

// *** testbench/prw_remap_lock_bench.sv ***
module prw_remap_lock_bench
   import prw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   `define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin miscompares++; \
      $display("BAD %s expected %h seen %h", nm, e, s); end end

   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] cfg3 = 32'h0;
   logic cfg_prog = 1'b0;
   logic key_we = 1'b0;
   logic [31:0] key_data = 32'h0;
   prw_lock_wr_t lock_wr = '0;
   prw_map_wr_t map_wr = '0;
   logic lock, unlocked, one_way;
   logic [31:0] sys_cfg;
   logic [PRW_NUM_OUT*PRW_SEL_W-1:0] out_sel;
   logic [PRW_NUM_IN*PRW_SEL_W-1:0] in_sel;
   int miscompares = 0;
   int checks = 0;

   // Half period of the 20 MHz clock
   always #25 ref_clk = ~ref_clk;

   prw_remap_lock DUT (
      .ref_clk_i(ref_clk),
      .rst_n_i(rst_n),
      .dev_cfg3_i(cfg3),
      .cfg_programmed_i(cfg_prog),
      .key_we_i(key_we),
      .key_data_i(key_data),
      .lock_wr_i(lock_wr),
      .map_wr_i(map_wr),
      .remap_write_lock_o(lock),
      .sys_cfg_o(sys_cfg),
      .unlocked_o(unlocked),
      .one_way_o(one_way),
      .out_sel_o(out_sel),
      .in_sel_o(in_sel)
   );

   // All stimulus moves at the falling edge, away from the sampling edge
   task tick;
      @(negedge ref_clk);
   endtask : tick

   task do_reset(input logic prog, input logic ow);
      cfg_prog = prog;
      cfg3 = 32'h0;
      cfg3[PRW_ONE_WAY_BIT] = ow;
      rst_n = 1'b0;
      repeat (5) tick;
      rst_n = 1'b1;
      // One-way is captured on the first edge, so requests start on the third
      repeat (2) tick;
   endtask : do_reset

   task unlock;
      key_we = 1'b1;
      key_data = PRW_KEY1;
      tick;
      key_data = PRW_KEY2;
      tick;
      key_we = 1'b0;
      tick;
   endtask : unlock

   task wr_lock(input logic v);
      lock_wr = '{1'b1, v};
      tick;
      lock_wr.we = 1'b0;
      tick;
   endtask : wr_lock

   task wr_map(input logic o, input logic [3:0] i, input logic [3:0] s);
      map_wr = '{1'b1, o, i, s};
      tick;
      map_wr.we = 1'b0;
      tick;
   endtask : wr_map

   task scn_reset_state;
      do_reset(1'b0, 1'b0);
      `CHK("one_way", 1'b1, one_way)
      `CHK("lock", 1'b0, lock)
      `CHK("out_sel", 32'h0, out_sel)
      `CHK("in_sel", 32'h0, in_sel)
   endtask : scn_reset_state

   task scn_two_way;
      do_reset(1'b1, 1'b0);
      `CHK("one_way", 1'b0, one_way)
      wr_lock(1'b1);
      `CHK("lock", 1'b0, lock)
      unlock;
      `CHK("unlocked", 1'b1, unlocked)
      wr_lock(1'b1);
      `CHK("lock", 1'b1, lock)
      `CHK("sys_cfg", 32'h1 << PRW_LOCK_BIT, sys_cfg)
      wr_map(1'b1, 4'h2, 4'h5);
      `CHK("out_sel", 32'h0, out_sel)
      unlock;
      wr_lock(1'b0);
      `CHK("lock", 1'b0, lock)
      `CHK("sys_cfg", 32'h0, sys_cfg)
      wr_map(1'b1, 4'h2, 4'hF);
      wr_map(1'b0, 4'h7, 4'hA);
      `CHK("out_sel", 32'h0000_0F00, out_sel)
      `CHK("in_sel", 32'hA000_0000, in_sel)
      wr_map(1'b1, 4'h8, 4'h1);
      `CHK("out_sel", 32'h0000_0F00, out_sel)
      unlock;
      repeat (14) tick;
      `CHK("unlocked", 1'b1, unlocked)
      tick;
      `CHK("unlocked", 1'b0, unlocked)
      wr_lock(1'b1);
      `CHK("lock", 1'b0, lock)
   endtask : scn_two_way

   task scn_one_way;
      do_reset(1'b1, 1'b1);
      wr_map(1'b1, 4'h0, 4'h3);
      unlock;
      wr_lock(1'b1);
      // Once set, the key sequence must not reopen the window
      unlock;
      `CHK("unlocked", 1'b0, unlocked)
      wr_lock(1'b0);
      `CHK("lock", 1'b1, lock)
      wr_map(1'b1, 4'h0, 4'h9);
      `CHK("out_sel", 32'h0000_0003, out_sel)
      wr_map(1'b0, 4'h1, 4'h6);
      `CHK("in_sel", 32'h0, in_sel)
      do_reset(1'b1, 1'b1);
      `CHK("lock", 1'b0, lock)
      `CHK("out_sel", 32'h0, out_sel)
   endtask : scn_one_way

   task results;
      if (miscompares == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   initial begin
      scn_reset_state;
      scn_two_way;
      scn_one_way;
      results;
   end
endmodule : prw_remap_lock_bench
